// ===== hw/rtr_pkg.sv
// Purpose: Constants, opcodes and decode for the transfer/RAM-addressing executor
// Assumes: 4-bit core; 10-bit instruction words presented over the register bus
// Notes:   Byte offsets are word aligned; reserved bits read as zero
package rtr_pkg;

  // Data widths
  localparam int NIB_W   = 4;
  localparam int E_W     = 8;
  localparam int D_W     = 3;
  localparam int Z_W     = 2;
  localparam int SP_W    = 3;
  localparam int INSTR_W = 10;
  localparam int PTR_W   = Z_W + 2 * NIB_W;
  localparam int ADDR_W  = 6;
  localparam int DATA_W  = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_INSTR  = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_ACC    = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_B      = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_E      = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_D      = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_Z      = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_X      = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_Y      = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_SP     = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h24;
  localparam logic [ADDR_W-1:0] OFS_RADDR  = 6'h28;
  localparam logic [ADDR_W-1:0] OFS_RDATA  = 6'h2c;

  // Status bit positions
  localparam int ST_CARRY = 0;
  localparam int ST_SKIP  = 1;
  localparam int ST_XYRUN = 2;

  // Reset values
  localparam logic [NIB_W-1:0] NIB_RST = 4'h0;
  localparam logic [E_W-1:0]   E_RST   = 8'h00;
  localparam logic [D_W-1:0]   D_RST   = 3'h0;
  localparam logic [Z_W-1:0]   Z_RST   = 2'h0;
  localparam logic [SP_W-1:0]  SP_RST  = 3'h7;

  // Skip thresholds of the Y counter
  localparam logic [NIB_W-1:0] Y_WRAP_UP = 4'h0;
  localparam logic [NIB_W-1:0] Y_WRAP_DN = 4'hf;

  // Full opcodes
  localparam logic [9:0] OPC_B2A    = 10'h01e;
  localparam logic [9:0] OPC_A2B    = 10'h00e;
  localparam logic [9:0] OPC_Y2A    = 10'h01f;
  localparam logic [9:0] OPC_A2Y    = 10'h00c;
  localparam logic [9:0] OPC_PACK   = 10'h01a;
  localparam logic [9:0] OPC_UNPACK = 10'h02a;
  localparam logic [9:0] OPC_A2D    = 10'h029;
  localparam logic [9:0] OPC_D2A    = 10'h051;
  localparam logic [9:0] OPC_Z2A    = 10'h053;
  localparam logic [9:0] OPC_X2A    = 10'h052;
  localparam logic [9:0] OPC_SP2A   = 10'h050;
  localparam logic [9:0] OPC_INCY   = 10'h013;
  localparam logic [9:0] OPC_DECY   = 10'h017;
  // Opcode prefixes of immediate forms
  localparam logic [1:0] PFX_LDXY  = 2'h3;
  localparam logic [7:0] PFX_LDZ   = 8'h12;
  localparam logic [5:0] PFX_LDRAM = 6'h2c;
  localparam logic [5:0] PFX_SWAP  = 6'h2d;
  localparam logic [5:0] PFX_SWAPD = 6'h2f;
  localparam logic [5:0] PFX_SWAPI = 6'h2e;
  localparam logic [5:0] PFX_STORE = 6'h2b;

  typedef enum logic [4:0] {
    OP_NOP, OP_B2A, OP_A2B, OP_Y2A, OP_A2Y, OP_PACK, OP_UNPACK, OP_A2D,
    OP_D2A, OP_Z2A, OP_X2A, OP_SP2A, OP_LDXY, OP_LDZ, OP_INCY, OP_DECY,
    OP_LDRAM, OP_SWAP, OP_SWAPD, OP_SWAPI, OP_STORE
  } rtr_op_t;

  typedef enum {ST_IDLE, ST_LOOK, ST_EXEC, ST_ACK} rtr_state_t;

  // Instruction word to operation class
  function automatic rtr_op_t rtr_decode(input logic [INSTR_W-1:0] w);
    rtr_op_t op;
    op = OP_NOP;
    if (w[9:8] == PFX_LDXY) op = OP_LDXY;
    else if (w[9:2] == PFX_LDZ) op = OP_LDZ;
    else if (w[9:4] == PFX_LDRAM) op = OP_LDRAM;
    else if (w[9:4] == PFX_SWAP) op = OP_SWAP;
    else if (w[9:4] == PFX_SWAPD) op = OP_SWAPD;
    else if (w[9:4] == PFX_SWAPI) op = OP_SWAPI;
    else if (w[9:4] == PFX_STORE) op = OP_STORE;
    else if (w == OPC_B2A) op = OP_B2A;
    else if (w == OPC_A2B) op = OP_A2B;
    else if (w == OPC_Y2A) op = OP_Y2A;
    else if (w == OPC_A2Y) op = OP_A2Y;
    else if (w == OPC_PACK) op = OP_PACK;
    else if (w == OPC_UNPACK) op = OP_UNPACK;
    else if (w == OPC_A2D) op = OP_A2D;
    else if (w == OPC_D2A) op = OP_D2A;
    else if (w == OPC_Z2A) op = OP_Z2A;
    else if (w == OPC_X2A) op = OP_X2A;
    else if (w == OPC_SP2A) op = OP_SP2A;
    else if (w == OPC_INCY) op = OP_INCY;
    else if (w == OPC_DECY) op = OP_DECY;
    return op;
  endfunction

endpackage

// ===== hw/rtr_ram.sv
// Purpose: Nibble-wide data RAM with one synchronous read/write port
// Assumes: Read data appear one clock after the address
// Notes:   Contents are not reset, as in a real data RAM
`timescale 1ns/1ns
module rtr_ram #(
  parameter int DEPTH = 1024,
  parameter int AW    = 10,
  parameter int DW    = 4
) (
  input  wire logic          clk_i,
  // Port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_q [DEPTH];

  // Write and registered read share one address
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    rdata_o <= mem_q[addr_i];
  end

endmodule

// ===== hw/rtr_core.sv
// Purpose: Executes transfer and RAM-addressing instructions written over Avalon-MM
// Assumes: Master holds each request until it sees waitrequest low
// Notes:   Every access takes the same four-cycle path, so timing is fixed
`timescale 1ns/1ns
module rtr_core
  import rtr_pkg::*;
#(
  parameter int RAM_DEPTH = 1024
) (
  // Clock and reset
  input  wire logic                        ref_clk_i,
  input  wire logic                        nrst_i,
  // Avalon-MM slave
  input  wire logic [rtr_pkg::ADDR_W-1:0]  avs_address_i,
  input  wire logic                        avs_read_i,
  input  wire logic                        avs_write_i,
  input  wire logic [rtr_pkg::DATA_W-1:0]  avs_writedata_i,
  output logic      [rtr_pkg::DATA_W-1:0]  avs_readdata_o,
  output logic                             avs_waitrequest_o
);
  import rtr_pkg::*;

  localparam int RAM_AW = $clog2(RAM_DEPTH);

  // The RAM may not exceed the range of the pointer that addresses it
  if (RAM_DEPTH < 2 || RAM_DEPTH > (1 << PTR_W) || (1 << RAM_AW) != RAM_DEPTH) begin : g_chk
    $error("rtr_core: RAM_DEPTH must be a power of two up to 2**PTR_W");
  end

  // Reset synchroniser
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Core registers
  logic [NIB_W-1:0]  acc_q, acc_d;
  logic [NIB_W-1:0]  b_q, b_d;
  logic [E_W-1:0]    e_q, e_d;
  logic [D_W-1:0]    d_q, d_d;
  logic [Z_W-1:0]    z_q, z_d;
  logic [NIB_W-1:0]  x_q, x_d;
  logic [NIB_W-1:0]  y_q, y_d;
  logic [SP_W-1:0]   sp_q, sp_d;
  logic              carry_q, carry_d;
  logic              skip_q, skip_d;
  logic              xyrun_q, xyrun_d;
  logic [PTR_W-1:0]  raddr_q;

  // Captured request
  rtr_state_t            state_q;
  logic [ADDR_W-1:0]     addr_q;
  logic                  wr_q;
  logic [DATA_W-1:0]     wdata_q;
  logic [DATA_W-1:0]     rdata_q;

  // RAM port
  logic                  ram_we;
  logic [PTR_W-1:0]      ram_ptr;
  logic [NIB_W-1:0]      ram_wdata;
  logic [NIB_W-1:0]      ram_rdata;

  // Decode of the current instruction word
  logic                  is_instr;
  logic                  exec_go;
  rtr_op_t               op;
  logic [NIB_W-1:0]      imm_j;
  logic [NIB_W-1:0]      y_inc;
  logic [NIB_W-1:0]      y_dec;

  assign is_instr = wr_q && (addr_q == OFS_INSTR);
  assign exec_go  = (state_q == ST_EXEC) && is_instr;
  assign op       = rtr_decode(wdata_q[INSTR_W-1:0]);
  assign imm_j    = wdata_q[NIB_W-1:0];
  assign y_inc    = NIB_W'(y_q + 1'b1);
  assign y_dec    = NIB_W'(y_q - 1'b1);

  // Request flow: every access idles, looks up RAM, executes, acknowledges
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            state_q <= ST_LOOK;
          end
        end
        ST_LOOK: state_q <= ST_EXEC;
        ST_EXEC: state_q <= ST_ACK;
        ST_ACK:  state_q <= ST_IDLE;
      endcase
    end
  end

  // Request capture; the master holds it steady anyway
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      addr_q  <= '0;
      wr_q    <= 1'b0;
      wdata_q <= '0;
    end else if (state_q == ST_IDLE && (avs_read_i || avs_write_i)) begin
      addr_q  <= avs_address_i;
      wr_q    <= avs_write_i;
      wdata_q <= avs_writedata_i;
    end
  end

  assign avs_waitrequest_o = (state_q != ST_ACK);
  assign avs_readdata_o    = rdata_q;

  // Pointer is formed from registers before the EXEC edge updates them
  assign ram_ptr = is_instr ? {z_q, x_q, y_q} : raddr_q;

  // RAM writes happen only at the EXEC edge, one per access
  always_comb begin
    ram_we    = 1'b0;
    ram_wdata = acc_q;
    if (exec_go && !skip_q && !(op == OP_LDXY && xyrun_q)) begin
      ram_we = (op == OP_SWAP) || (op == OP_SWAPD) || (op == OP_SWAPI)
               || (op == OP_STORE);
    end else if (state_q == ST_EXEC && wr_q && addr_q == OFS_RDATA) begin
      ram_we    = 1'b1;
      ram_wdata = wdata_q[NIB_W-1:0];
    end
  end

  rtr_ram #(
    .DEPTH (RAM_DEPTH),
    .AW    (RAM_AW),
    .DW    (NIB_W)
  ) u_ram (
    .clk_i   (ref_clk_i),
    .we_i    (ram_we),
    .addr_i  (ram_ptr[RAM_AW-1:0]),
    .wdata_i (ram_wdata),
    .rdata_o (ram_rdata)
  );

  // Next state of the core registers
  always_comb begin
    acc_d   = acc_q;
    b_d     = b_q;
    e_d     = e_q;
    d_d     = d_q;
    z_d     = z_q;
    x_d     = x_q;
    y_d     = y_q;
    sp_d    = sp_q;
    carry_d = carry_q;
    skip_d  = skip_q;
    xyrun_d = xyrun_q;
    if (exec_go) begin
      // A run of loads stays a run even across skipped members
      xyrun_d = (op == OP_LDXY);
      skip_d  = 1'b0;
      if (skip_q || (op == OP_LDXY && xyrun_q)) begin
        // Fetched but without effect
      end else begin
        unique case (op)
          OP_B2A:    acc_d = b_q;
          OP_A2B:    b_d = acc_q;
          OP_Y2A:    acc_d = y_q;
          OP_A2Y:    y_d = acc_q;
          OP_PACK:   e_d = {b_q, acc_q};
          OP_UNPACK: begin
            b_d   = e_q[E_W-1:NIB_W];
            acc_d = e_q[NIB_W-1:0];
          end
          OP_A2D:    d_d = acc_q[D_W-1:0];
          OP_D2A:    acc_d = {1'b0, d_q};
          OP_Z2A:    acc_d = {2'b00, z_q};
          OP_X2A:    acc_d = x_q;
          OP_SP2A:   acc_d = {1'b0, sp_q};
          OP_LDXY: begin
            x_d = wdata_q[2*NIB_W-1:NIB_W];
            y_d = wdata_q[NIB_W-1:0];
          end
          OP_LDZ:    z_d = wdata_q[Z_W-1:0];
          OP_INCY: begin
            y_d    = y_inc;
            skip_d = (y_inc == Y_WRAP_UP);
          end
          OP_DECY: begin
            y_d    = y_dec;
            skip_d = (y_dec == Y_WRAP_DN);
          end
          OP_LDRAM: begin
            acc_d = ram_rdata;
            x_d   = x_q ^ imm_j;
          end
          OP_SWAP: begin
            acc_d = ram_rdata;
            x_d   = x_q ^ imm_j;
          end
          OP_SWAPD: begin
            acc_d  = ram_rdata;
            x_d    = x_q ^ imm_j;
            y_d    = y_dec;
            skip_d = (y_dec == Y_WRAP_DN);
          end
          OP_SWAPI: begin
            acc_d  = ram_rdata;
            x_d    = x_q ^ imm_j;
            y_d    = y_inc;
            skip_d = (y_inc == Y_WRAP_UP);
          end
          OP_STORE:  x_d = x_q ^ imm_j;
          default: begin
            // Unknown words act as no operation
          end
        endcase
      end
    end else if (state_q == ST_EXEC && wr_q) begin
      // Direct software access to the register file
      unique case (addr_q)
        OFS_ACC:    acc_d = wdata_q[NIB_W-1:0];
        OFS_B:      b_d = wdata_q[NIB_W-1:0];
        OFS_E:      e_d = wdata_q[E_W-1:0];
        OFS_D:      d_d = wdata_q[D_W-1:0];
        OFS_Z:      z_d = wdata_q[Z_W-1:0];
        OFS_X:      x_d = wdata_q[NIB_W-1:0];
        OFS_Y:      y_d = wdata_q[NIB_W-1:0];
        OFS_SP:     sp_d = wdata_q[SP_W-1:0];
        OFS_STATUS: carry_d = wdata_q[ST_CARRY];
        default: begin
          // Unmapped and read-only offsets ignore writes
        end
      endcase
    end
  end

  // Accumulator and B; a skipped or unknown word leaves both as they were
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      acc_q <= NIB_RST;
      b_q   <= NIB_RST;
    end else begin
      acc_q <= acc_d;
      b_q   <= b_d;
    end
  end

  // Pack register E and the three-bit D register
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      e_q <= E_RST;
      d_q <= D_RST;
    end else begin
      e_q <= e_d;
      d_q <= d_d;
    end
  end

  // RAM address registers; they change only at the EXEC edge, after the pointer was used
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      z_q <= Z_RST;
      x_q <= NIB_RST;
      y_q <= NIB_RST;
    end else begin
      z_q <= z_d;
      x_q <= x_d;
      y_q <= y_d;
    end
  end

  // Stack pointer and carry; no instruction of this group writes either
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sp_q    <= SP_RST;
      carry_q <= 1'b0;
    end else begin
      sp_q    <= sp_d;
      carry_q <= carry_d;
    end
  end

  // Sequencing flags: pending skip and the running chain of X/Y loads
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      skip_q  <= 1'b0;
      xyrun_q <= 1'b0;
    end else begin
      skip_q  <= skip_d;
      xyrun_q <= xyrun_d;
    end
  end

  // RAM window address register
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      raddr_q <= '0;
    end else if (state_q == ST_EXEC && wr_q && addr_q == OFS_RADDR) begin
      raddr_q <= wdata_q[PTR_W-1:0];
    end
  end

  // Read data are taken from pre-update state; writes leave them so the last read stands
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= '0;
    end else if (state_q == ST_EXEC) begin
      if (!wr_q) begin
        rdata_q <= '0;
        unique case (addr_q)
          OFS_ACC:    rdata_q[NIB_W-1:0] <= acc_q;
          OFS_B:      rdata_q[NIB_W-1:0] <= b_q;
          OFS_E:      rdata_q[E_W-1:0] <= e_q;
          OFS_D:      rdata_q[D_W-1:0] <= d_q;
          OFS_Z:      rdata_q[Z_W-1:0] <= z_q;
          OFS_X:      rdata_q[NIB_W-1:0] <= x_q;
          OFS_Y:      rdata_q[NIB_W-1:0] <= y_q;
          OFS_SP:     rdata_q[SP_W-1:0] <= sp_q;
          OFS_STATUS: begin
            rdata_q[ST_CARRY] <= carry_q;
            rdata_q[ST_SKIP]  <= skip_q;
            rdata_q[ST_XYRUN] <= xyrun_q;
          end
          OFS_RADDR:  rdata_q[PTR_W-1:0] <= raddr_q;
          OFS_RDATA:  rdata_q[NIB_W-1:0] <= ram_rdata;
          default: begin
            // Unmapped offsets read as zero
          end
        endcase
      end
    end
  end

endmodule

// ===== dv/rtr_core_chk.sv
// Purpose: Port-level checks on the transfer executor's register bus
// Assumes: One clock domain; reset input low clears all state except the RAM contents
// Notes:   Carry is mirrored from bus writes, since no instruction may touch it
`timescale 1ns/1ns
module rtr_core_chk
  import rtr_pkg::*;
#(
  parameter int RAM_DEPTH = 1024
) (
  // Clock and reset
  input  wire logic                       ref_clk_i,
  input  wire logic                       nrst_i,
  // Avalon-MM slave
  input  wire logic [rtr_pkg::ADDR_W-1:0] avs_address_i,
  input  wire logic                       avs_read_i,
  input  wire logic                       avs_write_i,
  input  wire logic [rtr_pkg::DATA_W-1:0] avs_writedata_i,
  input  wire logic [rtr_pkg::DATA_W-1:0] avs_readdata_o,
  input  wire logic                       avs_waitrequest_o
);
  logic carry_q;
  logic ack;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // Completion of an access is the one cycle with waitrequest low
  assign ack = (avs_waitrequest_o == 1'b0);
  // Mirror of carry: only a bus write to status may change it
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      carry_q <= 1'b0;
    end else if (ack && avs_write_i && avs_address_i == OFS_STATUS) begin
      carry_q <= avs_writedata_i[ST_CARRY];
    end
  end
  // Bus timing
  property p_answer; $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o [*3] ##1 ack; endproperty
  a_answer: assert property (p_answer) else $error("answer not three waits after request");
  property p_ack_one; ack |=> avs_waitrequest_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("waitrequest low for over one cycle");
  property p_ack_gap;
    ack |-> $past(avs_waitrequest_o, 1) && $past(avs_waitrequest_o, 2) && $past(avs_waitrequest_o, 3);
  endproperty
  a_ack_gap: assert property (p_ack_gap) else $error("answer came too early");
  property p_ack_req; ack |-> (avs_read_i || avs_write_i); endproperty
  a_ack_req: assert property (p_ack_req) else $error("answer without a request");
  property p_rd_hold; !avs_read_i |=> $stable(avs_readdata_o); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
  // Read values
  property p_unmapped;
    ack && avs_read_i && (avs_address_i[1:0] != 2'h0 || avs_address_i > OFS_RDATA ||
      avs_address_i == OFS_INSTR) |-> avs_readdata_o == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_upper; ack && avs_read_i |-> avs_readdata_o[DATA_W-1:10] == '0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  property p_three;
    ack && avs_read_i && (avs_address_i == OFS_D || avs_address_i == OFS_SP)
      |-> avs_readdata_o[DATA_W-1:3] == '0;
  endproperty
  a_three: assert property (p_three) else $error("three-bit register too wide");
  property p_carry;
    ack && avs_read_i && avs_address_i == OFS_STATUS |-> avs_readdata_o[ST_CARRY] == carry_q;
  endproperty
  a_carry: assert property (p_carry) else $error("carry changed by an instruction");
endmodule

bind rtr_core rtr_core_chk #(.RAM_DEPTH(RAM_DEPTH)) u_chk (
  .ref_clk_i        (ref_clk_i),
  .nrst_i           (nrst_i),
  .avs_address_i    (avs_address_i),
  .avs_read_i       (avs_read_i),
  .avs_write_i      (avs_write_i),
  .avs_writedata_i  (avs_writedata_i),
  .avs_readdata_o   (avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o)
);

// ===== dv/testbench.sv
// Purpose: Self-checking bench for the transfer and RAM-addressing executor
// Assumes: Master waits for waitrequest low and assumes no fixed latency
// Notes:   Scenarios run in order and share register state
`timescale 1ns/1ns
module testbench;
  import rtr_pkg::*;
  logic              ref_clk_i   = 1'b0;
  logic              nrst_i      = 1'b0;
  logic [ADDR_W-1:0] adr         = '0;
  logic              rd          = 1'b0;
  logic              wr          = 1'b0;
  logic [DATA_W-1:0] wd          = '0;
  logic [DATA_W-1:0] rdata;
  logic              wait_o;
  logic [DATA_W-1:0] q;
  int                error_cnt   = 0;
  int                comparisons = 0;
  int                cyc         = 0;

  rtr_core u_dut (
    .ref_clk_i        (ref_clk_i),
    .nrst_i           (nrst_i),
    .avs_address_i    (adr),
    .avs_read_i       (rd),
    .avs_write_i      (wr),
    .avs_writedata_i  (wd),
    .avs_readdata_o   (rdata),
    .avs_waitrequest_o(wait_o)
  );

  // Clock, and a cycle ceiling so a stuck handshake cannot hang the run
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // One access; held until waitrequest is seen low at a rising edge, data taken there
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [11:0] d);
    @(posedge ref_clk_i);
    wr  <= w;
    rd  <= ~w;
    adr <= a;
    wd  <= {20'h0, d};
    do @(posedge ref_clk_i); while (wait_o !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic set(input logic [ADDR_W-1:0] a, input logic [11:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic ex(input logic [INSTR_W-1:0] i);
    bus(1'b1, OFS_INSTR, {2'h0, i});
  endtask

  task automatic ck(input logic [ADDR_W-1:0] a, input logic [11:0] e);
    bus(1'b0, a, 12'h0);
    comparisons++;
    if (q !== {20'h0, e}) begin
      error_cnt++;
      $display("mismatch reg %h expected %h seen %h", a, e, q);
    end
  endtask

  // Reset values, unmapped and write-only places
  task automatic t_reset();
    ck(OFS_SP, {9'h0, SP_RST});
    ck(OFS_E, 12'h0);
    ck(OFS_INSTR, 12'h0);
    set(6'h30, 12'hf);
    ck(6'h30, 12'h0);
  endtask

  task automatic t_regs();
    set(OFS_ACC, 12'h3);
    set(OFS_B, 12'h9);
    ex(OPC_B2A);
    ck(OFS_ACC, 12'h9);
    set(OFS_ACC, 12'h6);
    ex(OPC_A2B);
    ck(OFS_B, 12'h6);
    ck(OFS_ACC, 12'h6);
    set(OFS_Y, 12'hc);
    ex(OPC_Y2A);
    ck(OFS_ACC, 12'hc);
    set(OFS_ACC, 12'h5);
    ex(OPC_A2Y);
    ck(OFS_Y, 12'h5);
    set(OFS_B, 12'ha);
    set(OFS_ACC, 12'h3);
    ex(OPC_PACK);
    ck(OFS_E, 12'ha3);
    set(OFS_E, 12'h5c);
    ex(OPC_UNPACK);
    ck(OFS_B, 12'h5);
    ck(OFS_ACC, 12'hc);
    set(OFS_ACC, 12'he);
    ex(OPC_A2D);
    ck(OFS_D, 12'h6);
    set(OFS_ACC, 12'hf);
    ex(OPC_D2A);
    ck(OFS_ACC, 12'h6);
    set(OFS_Z, 12'h3);
    set(OFS_ACC, 12'hf);
    ex(OPC_Z2A);
    ck(OFS_ACC, 12'h3);
    set(OFS_X, 12'hb);
    ex(OPC_X2A);
    ck(OFS_ACC, 12'hb);
    set(OFS_SP, 12'h5);
    set(OFS_ACC, 12'hf);
    ex(OPC_SP2A);
    ck(OFS_ACC, 12'h5);
  endtask

  // A run of three immediate X/Y loads: only the first may land
  task automatic t_lxy();
    ex({PFX_LDXY, 4'ha, 4'h3});
    ck(OFS_Y, 12'h3);
    ck(OFS_STATUS, 12'h4);
    ex({PFX_LDXY, 4'h5, 4'h6});
    ex({PFX_LDXY, 4'h7, 4'h8});
    ck(OFS_X, 12'ha);
    ck(OFS_Y, 12'h3);
    // An unknown word is no load, so it ends the run
    ex(10'h000);
    ex({PFX_LDXY, 4'h5, 4'h6});
    ck(OFS_X, 12'h5);
    ex({PFX_LDZ, 2'h2});
    ck(OFS_Z, 12'h2);
  endtask

  // Y wrap both ways; the skipped instruction must leave A, B and carry alone
  task automatic t_skip();
    set(OFS_STATUS, 12'h1);
    set(OFS_Y, 12'hf);
    ex(OPC_INCY);
    ck(OFS_STATUS, 12'h3);
    set(OFS_B, 12'h9);
    set(OFS_ACC, 12'h2);
    ex(OPC_B2A);
    ck(OFS_ACC, 12'h2);
    ck(OFS_STATUS, 12'h1);
    set(OFS_Y, 12'h4);
    ex(OPC_INCY);
    ex(OPC_B2A);
    ck(OFS_ACC, 12'h9);
    set(OFS_Y, 12'h0);
    ex(OPC_DECY);
    ck(OFS_Y, 12'hf);
    // A differs from B, so a copy that wrongly runs would show
    set(OFS_ACC, 12'h4);
    ex(OPC_A2B);
    ck(OFS_B, 12'h9);
    ex(OPC_DECY);
    ex(OPC_A2B);
    ck(OFS_B, 12'h4);
  endtask

  // RAM at {Z,X,Y}, with a decoy at the post-XOR address
  task automatic t_ram();
    set(OFS_Z, 12'h1);
    set(OFS_X, 12'h6);
    set(OFS_Y, 12'h2);
    set(OFS_RADDR, 12'h162);
    set(OFS_RDATA, 12'h7);
    set(OFS_RADDR, 12'h132);
    set(OFS_RDATA, 12'h4);
    ex({PFX_LDRAM, 4'h5});
    ck(OFS_ACC, 12'h7);
    ck(OFS_X, 12'h3);
    ex({PFX_SWAP, 4'h5});
    ck(OFS_ACC, 12'h4);
    ck(OFS_RDATA, 12'h7);
    set(OFS_Y, 12'h0);
    set(OFS_RADDR, 12'h160);
    set(OFS_RDATA, 12'h9);
    ex({PFX_SWAPD, 4'h0});
    ck(OFS_RDATA, 12'h4);
    ck(OFS_STATUS, 12'h3);
    ex(OPC_A2B);
    ck(OFS_B, 12'h4);
    set(OFS_RADDR, 12'h16f);
    set(OFS_RDATA, 12'h3);
    ex({PFX_SWAPI, 4'hf});
    ck(OFS_RDATA, 12'h9);
    ck(OFS_Y, 12'h0);
    ck(OFS_STATUS, 12'h3);
    ex(OPC_B2A);
    ex({PFX_STORE, 4'h1});
    ck(OFS_X, 12'h8);
    set(OFS_RADDR, 12'h190);
    ck(OFS_RDATA, 12'h3);
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    t_reset();
    t_regs();
    t_lxy();
    t_skip();
    t_ram();
    summarize();
  end
endmodule
